// ---- logic/mar_pkg.sv ----
// package of constants and types for the rotate/subtract/swap/power-down execution block
//
// Contract
// RULE1 - the power-down instruction clears the watchdog counter to zero and clears its prescaler.
// RULE2 - the power-down instruction sets timeout_flag_n to one, clears powerdown_flag_n, and leaves port_wake_flag alone.
// RULE3 - after the flag update the power-down instruction enters the low-power state with the oscillator halted.
// RULE4 - rotate_left_op shifts the file value left one place through carry and changes only carry.
// RULE5 - rotate_right_op shifts the file value right one place through carry and changes only carry.
// RULE6 - subtract_acc_from_file_op computes file minus accumulator in two's complement and updates carry, digit carry, zero.
// RULE7 - nibble_exchange_op moves file bits 3:0 to result 7:4 and 7:4 to 3:0 and changes no flag.
// RULE8 - a destination bit of zero sends the result to the accumulator, one writes it back to the file register.
// RULE9 - left rotate takes old carry into bit 0 and bit 7 out to carry; right rotate takes carry into bit 7, bit 0 out.
// RULE10 - subtract sets carry and digit carry when there is no borrow, and zero when the result is zero.
package mar_pkg;

    // ======================================================
    // widths, reset and sleep values, destination codes and nibble offsets
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int WATCHDOG_W = 8;
    localparam int PRE_W = 8;
    localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [7:0] PRE_CLEAR = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic TIMEOUT_N_RESET = 1'h1;
    localparam logic POWERDOWN_N_RESET = 1'h1;
    localparam logic TIMEOUT_N_SLEEP = 1'h1;
    localparam logic POWERDOWN_N_SLEEP = 1'h0;
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_FILE = 1'h1;
    localparam int NIB_LO = 0;
    localparam int NIB_HI = 4;

    // ======================================================
    // operation codes
    typedef enum logic [2:0] {
        MAR_OP_NONE,
        MAR_OP_ROTATE_LEFT,
        MAR_OP_ROTATE_RIGHT,
        MAR_OP_SUBTRACT,
        MAR_OP_NIBBLE_EXCHANGE,
        MAR_OP_SLEEP
    } mar_op_e;

    typedef enum logic [1:0] {
        MAR_RUN,
        MAR_SLEEPING
    } mar_state_e;

endpackage

// ---- logic/mar_alu_if.sv ----
// interface carrying operands and result between the control and the arithmetic unit
`timescale 1ns/1ps
interface mar_alu_if;
    mar_pkg::mar_op_e op;
    logic [7:0] file_val;
    logic [7:0] acc_val;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic digit_carry_out;
    logic zero_out;
    logic carry_we;
    logic digit_carry_we;
    logic zero_we;
    logic result_valid;

    modport ctl (output op, output file_val, output acc_val, output carry_in,
        input result, input carry_out, input digit_carry_out, input zero_out,
        input carry_we, input digit_carry_we, input zero_we, input result_valid);
    modport alu (input op, input file_val, input acc_val, input carry_in,
        output result, output carry_out, output digit_carry_out, output zero_out,
        output carry_we, output digit_carry_we, output zero_we, output result_valid);
endinterface

// ---- logic/mar_alu.sv ----
// combinational arithmetic unit for rotate, subtract and nibble exchange
`timescale 1ns/1ps
module mar_alu (
    mar_alu_if.alu a
);
    logic [8:0] diff;
    logic [4:0] ldiff;

    // ======================================================
    // result and flag strobes
    always_comb begin
        diff = {1'b0, a.file_val} - {1'b0, a.acc_val};
        ldiff = {1'b0, a.file_val[3:0]} - {1'b0, a.acc_val[3:0]};
        a.result = a.file_val;
        a.carry_out = a.carry_in;
        a.digit_carry_out = 1'b0;
        a.zero_out = 1'b0;
        a.carry_we = 1'b0;
        a.digit_carry_we = 1'b0;
        a.zero_we = 1'b0;
        a.result_valid = 1'b0;
        case (a.op)
            mar_pkg::MAR_OP_ROTATE_LEFT: begin
                a.result = {a.file_val[6:0], a.carry_in}; // [RULE4] [RULE9]
                a.carry_out = a.file_val[7]; // [RULE9]
                a.carry_we = 1'b1; // [RULE4]
                a.result_valid = 1'b1;
            end
            mar_pkg::MAR_OP_ROTATE_RIGHT: begin
                a.result = {a.carry_in, a.file_val[7:1]}; // [RULE5] [RULE9]
                a.carry_out = a.file_val[0]; // [RULE9]
                a.carry_we = 1'b1; // [RULE5]
                a.result_valid = 1'b1;
            end
            mar_pkg::MAR_OP_SUBTRACT: begin
                a.result = diff[7:0]; // [RULE6]
                a.carry_out = ~diff[8]; // [RULE10]
                a.digit_carry_out = ~ldiff[4]; // [RULE10]
                a.zero_out = (diff[7:0] == 8'h00); // [RULE10]
                a.carry_we = 1'b1; // [RULE6]
                a.digit_carry_we = 1'b1;
                a.zero_we = 1'b1;
                a.result_valid = 1'b1;
            end
            mar_pkg::MAR_OP_NIBBLE_EXCHANGE: begin
                a.result = {a.file_val[mar_pkg::NIB_LO +: 4], a.file_val[mar_pkg::NIB_HI +: 4]}; // [RULE7]
                a.result_valid = 1'b1;
            end
            default: begin
                a.result = a.file_val;
            end
        endcase
    end
endmodule

// ---- logic/mar_core.sv ----
// execution block top: operation issue, destination steering, flags, watchdog clear and sleep
`timescale 1ns/1ps
module mar_core (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic op_valid,
    input wire mar_pkg::mar_op_e op_code,
    input wire logic dest_sel,
    input wire logic [4:0] file_addr,
    input wire logic [7:0] file_rdata,
    input wire logic wake_req,
    input wire logic watchdog_tick,
    input wire logic port_wake_set,
    output logic op_ready,
    output logic [7:0] acc,
    output logic file_we,
    output logic [4:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic port_wake_flag,
    output logic [7:0] watchdog_counter,
    output logic [7:0] watchdog_prescaler,
    output logic osc_run
);
    typedef struct packed {
        mar_pkg::mar_state_e st;
        logic [7:0] acc;
        logic fwe;
        logic [4:0] fwa;
        logic [7:0] fwd;
        logic c;
        logic dcy;
        logic z;
        logic tmo_n;
        logic pwrdn_n;
        logic pwf;
        logic [7:0] wdog;
        logic [7:0] pre;
    } mar_state_s;

    mar_state_s s_q, s_d;
    mar_alu_if alu_bus ();
    logic issue;

    // ======================================================
    // arithmetic unit
    assign alu_bus.op = op_code;
    assign alu_bus.file_val = file_rdata;
    assign alu_bus.acc_val = s_q.acc;
    assign alu_bus.carry_in = s_q.c;
    mar_alu u_alu (
        .a(alu_bus.alu)
    );

    // ======================================================
    // next state
    assign op_ready = (s_q.st == mar_pkg::MAR_RUN);
    assign issue = op_valid & op_ready;

    always_comb begin
        s_d = s_q;
        s_d.fwe = 1'b0;
        if (port_wake_set) begin
            s_d.pwf = 1'b1;
        end
        case (s_q.st)
            mar_pkg::MAR_RUN: begin
                // watchdog keeps counting while running
                if (watchdog_tick) begin
                    s_d.pre = s_q.pre + 8'h01;
                    if (s_q.pre == 8'hFF) begin
                        s_d.wdog = s_q.wdog + 8'h01;
                    end
                end
                if (issue && op_code == mar_pkg::MAR_OP_SLEEP) begin
                    s_d.wdog = mar_pkg::WATCHDOG_CLEAR; // [RULE1]
                    s_d.pre = mar_pkg::PRE_CLEAR; // [RULE1]
                    s_d.tmo_n = mar_pkg::TIMEOUT_N_SLEEP; // [RULE2]
                    s_d.pwrdn_n = mar_pkg::POWERDOWN_N_SLEEP; // [RULE2]
                    s_d.st = mar_pkg::MAR_SLEEPING; // [RULE3]
                end else if (issue && alu_bus.result_valid) begin
                    if (dest_sel == mar_pkg::DEST_ACC) begin
                        s_d.acc = alu_bus.result; // [RULE8]
                    end else begin
                        s_d.fwe = 1'b1; // [RULE8]
                        s_d.fwa = file_addr;
                        s_d.fwd = alu_bus.result;
                    end
                    if (alu_bus.carry_we) begin
                        s_d.c = alu_bus.carry_out; // [RULE4] [RULE5] [RULE6]
                    end
                    if (alu_bus.digit_carry_we) begin
                        s_d.dcy = alu_bus.digit_carry_out; // [RULE6]
                    end
                    if (alu_bus.zero_we) begin
                        s_d.z = alu_bus.zero_out; // [RULE6]
                    end
                end
            end
            mar_pkg::MAR_SLEEPING: begin
                // oscillator halted; only a wake request resumes
                if (wake_req) begin
                    s_d.st = mar_pkg::MAR_RUN;
                end
            end
            default: begin
                s_d.st = mar_pkg::MAR_RUN;
            end
        endcase
    end

    // ======================================================
    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= mar_pkg::MAR_RUN;
            s_q.acc <= mar_pkg::ACC_RESET;
            s_q.tmo_n <= mar_pkg::TIMEOUT_N_RESET;
            s_q.pwrdn_n <= mar_pkg::POWERDOWN_N_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // outputs
    assign acc = s_q.acc;
    assign file_we = s_q.fwe;
    assign file_waddr = s_q.fwa;
    assign file_wdata = s_q.fwd;
    assign carry_flag = s_q.c;
    assign digit_carry_flag = s_q.dcy;
    assign zero_flag = s_q.z;
    assign timeout_flag_n = s_q.tmo_n;
    assign powerdown_flag_n = s_q.pwrdn_n;
    assign port_wake_flag = s_q.pwf;
    assign watchdog_counter = s_q.wdog;
    assign watchdog_prescaler = s_q.pre;
    assign osc_run = (s_q.st == mar_pkg::MAR_RUN); // [RULE3]

    // ======================================================
    // checks
    // all checks sample on the core clock and rest while reset is held
    property p_sleep_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (issue && op_code == mar_pkg::MAR_OP_SLEEP) |=> (watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00);
    endproperty
    sleep_wdog_clear_a: assert property (p_sleep_clear) else $error("watchdog not cleared by sleep"); // [RULE1]
    sleep_flags_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE2]
        (issue && op_code == mar_pkg::MAR_OP_SLEEP) |=>
        (timeout_flag_n && !powerdown_flag_n && port_wake_flag == ($past(port_wake_flag) | $past(port_wake_set))))
        else $error("sleep flags wrong");
    osc_halt_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE3]
        (issue && op_code == mar_pkg::MAR_OP_SLEEP) |=> (!osc_run && !op_ready))
        else $error("oscillator not halted");
    // halted core: no counting and no writes until a wake request
    halt_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE3]
        (!osc_run && !wake_req) |=> (!osc_run && !op_ready && !file_we && $stable(watchdog_prescaler)))
        else $error("core ran while halted");
    wake_resume_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE3]
        (!osc_run && wake_req) |=> (osc_run && op_ready))
        else $error("core not resumed by wake request");
    rotl_flags_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE4]
        (issue && op_code == mar_pkg::MAR_OP_ROTATE_LEFT) |=>
        (carry_flag == $past(file_rdata[7]) && zero_flag == $past(zero_flag) && $stable(digit_carry_flag)))
        else $error("rotate left flag error");
    rotr_flags_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE5]
        (issue && op_code == mar_pkg::MAR_OP_ROTATE_RIGHT) |=>
        (carry_flag == $past(file_rdata[0]) && $stable(zero_flag) && $stable(digit_carry_flag)))
        else $error("rotate right flag error");
    sub_value_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE6]
        (issue && op_code == mar_pkg::MAR_OP_SUBTRACT && dest_sel == 1'b0) |=>
        (acc == 8'($past(file_rdata) - $past(acc)) && zero_flag == (acc == 8'h00)))
        else $error("subtract result wrong");
    sub_borrow_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE10]
        (issue && op_code == mar_pkg::MAR_OP_SUBTRACT) |=>
        (carry_flag == ($past(file_rdata) >= $past(acc)) &&
        digit_carry_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0]))))
        else $error("subtract borrow flags wrong");
    swap_value_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE7]
        (issue && op_code == mar_pkg::MAR_OP_NIBBLE_EXCHANGE && dest_sel) |=>
        (file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(carry_flag)
        && $stable(zero_flag) && $stable(digit_carry_flag)))
        else $error("nibble exchange wrong");
    dest_acc_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE8]
        (issue && alu_bus.result_valid && !dest_sel) |=> !file_we)
        else $error("file written for accumulator destination");
    rotl_data_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE9]
        (issue && op_code == mar_pkg::MAR_OP_ROTATE_LEFT && dest_sel) |=>
        (file_wdata == {$past(file_rdata[6:0]), $past(carry_flag)} && file_waddr == $past(file_addr)))
        else $error("rotate left data wrong");
    rotr_data_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE9]
        (issue && op_code == mar_pkg::MAR_OP_ROTATE_RIGHT && !dest_sel) |=>
        (acc == {$past(carry_flag), $past(file_rdata[7:1])} && !file_we))
        else $error("rotate right data wrong");
    dest_file_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE8]
        (issue && alu_bus.result_valid && dest_sel) |=>
        (file_we && file_waddr == $past(file_addr) && $stable(acc)))
        else $error("file write-back missing");
    sub_file_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE6]
        (issue && op_code == mar_pkg::MAR_OP_SUBTRACT && dest_sel) |=>
        (file_wdata == 8'($past(file_rdata) - $past(acc)) && zero_flag == (file_wdata == 8'h00)))
        else $error("subtract write-back wrong");
    swap_acc_a: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE7]
        (issue && op_code == mar_pkg::MAR_OP_NIBBLE_EXCHANGE && !dest_sel) |=>
        (acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(carry_flag)
        && $stable(zero_flag) && $stable(digit_carry_flag)))
        else $error("nibble exchange to accumulator wrong");
    // scenarios worth seeing at least once
    cov_sleep_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        issue && op_code == mar_pkg::MAR_OP_SLEEP ##[1:20] wake_req);
    cov_sub_zero_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        issue && op_code == mar_pkg::MAR_OP_SUBTRACT ##1 zero_flag);
    cov_rotr_file_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        issue && op_code == mar_pkg::MAR_OP_ROTATE_RIGHT && dest_sel);
    cov_swap_acc_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        issue && op_code == mar_pkg::MAR_OP_NIBBLE_EXCHANGE && !dest_sel);
    cov_sub_borrow_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        issue && op_code == mar_pkg::MAR_OP_SUBTRACT ##1 !carry_flag);
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the rotate/subtract/swap/power-down execution block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
    // ==========================================================
    // clock, reset and stimulus signals
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic op_valid = 1'b0;
    mar_pkg::mar_op_e op_code = mar_pkg::MAR_OP_NONE;
    logic dest_sel = 1'b0;
    logic [4:0] file_addr = 5'h00;
    logic [7:0] file_rdata = 8'h00;
    logic wake_req = 1'b0;
    logic watchdog_tick = 1'b0;
    logic port_wake_set = 1'b0;
    logic op_ready, file_we, carry_flag, digit_carry_flag, zero_flag;
    logic timeout_flag_n, powerdown_flag_n, port_wake_flag, osc_run;
    logic [7:0] acc, file_wdata, watchdog_counter, watchdog_prescaler;
    logic [4:0] file_waddr;
    logic [7:0] acc_m = 8'h00;
    logic c_m = 1'b0, dcy_m = 1'b0, z_m = 1'b0;
    logic halted_m = 1'b0;
    logic [7:0] vals [6] = '{8'h81, 8'h00, 8'h7F, 8'h3C, 8'hF0, 8'h01};
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    mar_pkg::mar_op_e ops [5] = '{mar_pkg::MAR_OP_ROTATE_LEFT, mar_pkg::MAR_OP_SUBTRACT,
        mar_pkg::MAR_OP_ROTATE_RIGHT, mar_pkg::MAR_OP_NIBBLE_EXCHANGE, mar_pkg::MAR_OP_NONE};

    always #10 core_clk = ~core_clk;

    mar_core DUT (.core_clk(core_clk), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code),
        .dest_sel(dest_sel), .file_addr(file_addr), .file_rdata(file_rdata), .wake_req(wake_req),
        .watchdog_tick(watchdog_tick), .port_wake_set(port_wake_set), .op_ready(op_ready), .acc(acc),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n), .port_wake_flag(port_wake_flag),
        .watchdog_counter(watchdog_counter), .watchdog_prescaler(watchdog_prescaler), .osc_run(osc_run));

    // ==========================================================
    // verdict and hang guard
    task automatic stop_test();
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ==========================================================
    // one operation: drive, let the taking edge pass, compare with the model
    task automatic do_op(input mar_pkg::mar_op_e o, input logic d, input logic [4:0] a, input logic [7:0] f);
        logic [7:0] r;
        logic we;
        mar_pkg::mar_op_e eo;
        @(posedge core_clk);
        op_valid <= 1'b1;
        op_code <= o;
        dest_sel <= d;
        file_addr <= a;
        file_rdata <= f;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1;
        r = acc_m;
        we = 1'b0;
        // a halted core refuses every request
        if (halted_m) begin
            eo = mar_pkg::MAR_OP_NONE;
        end else begin
            eo = o;
        end
        case (eo)
            mar_pkg::MAR_OP_ROTATE_LEFT: begin
                r = {f[6:0], c_m};
                c_m = f[7];
            end
            mar_pkg::MAR_OP_ROTATE_RIGHT: begin
                r = {c_m, f[7:1]};
                c_m = f[0];
            end
            mar_pkg::MAR_OP_SUBTRACT: begin
                r = f - acc_m;
                c_m = (f >= acc_m);
                dcy_m = (f[3:0] >= acc_m[3:0]);
                z_m = (r == 8'h00);
            end
            mar_pkg::MAR_OP_NIBBLE_EXCHANGE: begin
                r = {f[3:0], f[7:4]};
            end
            mar_pkg::MAR_OP_SLEEP: begin
                halted_m = 1'b1;
            end
            default: begin
            end
        endcase
        if (eo != mar_pkg::MAR_OP_NONE && eo != mar_pkg::MAR_OP_SLEEP) begin
            we = d;
            if (d == mar_pkg::DEST_ACC) begin
                acc_m = r;
            end
        end
        `CHK("file_we", we, file_we)
        if (we) begin
            `CHK("file_wdata", r, file_wdata)
            `CHK("file_waddr", a, file_waddr)
        end
        `CHK("acc", acc_m, acc)
        `CHK("carry", c_m, carry_flag)
        `CHK("digit_carry", dcy_m, digit_carry_flag)
        `CHK("zero", z_m, zero_flag)
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        #1;
        `CHK("timeout_n reset", mar_pkg::TIMEOUT_N_RESET, timeout_flag_n)
        `CHK("powerdown_n reset", mar_pkg::POWERDOWN_N_RESET, powerdown_flag_n)
        `CHK("osc reset", 1'b1, osc_run)
        // every op except sleep with both destinations over a spread of file values
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 5; k++) begin
                do_op(ops[k], 1'b0, 5'(i + k), vals[i]);
                do_op(ops[k], 1'b1, 5'h1F - 5'(k), vals[5 - i]);
            end
        end
        // subtract to exactly zero, then with a low-nibble borrow only
        do_op(mar_pkg::MAR_OP_SUBTRACT, 1'b1, 5'h07, acc_m);
        do_op(mar_pkg::MAR_OP_ROTATE_LEFT, 1'b0, 5'h02, 8'h0F);
        do_op(mar_pkg::MAR_OP_SUBTRACT, 1'b1, 5'h03, 8'h30);
        // wake flag and watchdog activity before power-down
        @(posedge core_clk);
        port_wake_set <= 1'b1;
        repeat (300) begin
            @(posedge core_clk);
            port_wake_set <= 1'b0;
            watchdog_tick <= 1'b1;
        end
        @(posedge core_clk);
        watchdog_tick <= 1'b0;
        #1;
        `CHK("watchdog before", 8'h01, watchdog_counter)
        `CHK("pre before", 8'h2C, watchdog_prescaler)
        `CHK("wake flag", 1'b1, port_wake_flag)
        do_op(mar_pkg::MAR_OP_SLEEP, 1'b0, 5'h00, 8'h00);
        `CHK("watchdog sleep", mar_pkg::WATCHDOG_CLEAR, watchdog_counter)
        `CHK("pre sleep", mar_pkg::PRE_CLEAR, watchdog_prescaler)
        `CHK("timeout_n sleep", mar_pkg::TIMEOUT_N_SLEEP, timeout_flag_n)
        `CHK("powerdown_n sleep", mar_pkg::POWERDOWN_N_SLEEP, powerdown_flag_n)
        `CHK("wake kept", 1'b1, port_wake_flag)
        `CHK("osc sleep", 1'b0, osc_run)
        `CHK("ready sleep", 1'b0, op_ready)
        // requests and ticks while halted are ignored
        do_op(mar_pkg::MAR_OP_ROTATE_LEFT, 1'b1, 5'h04, 8'hAA);
        @(posedge core_clk);
        watchdog_tick <= 1'b1;
        @(posedge core_clk);
        watchdog_tick <= 1'b0;
        wake_req <= 1'b1;
        #1;
        `CHK("pre halted", 8'h00, watchdog_prescaler)
        `CHK("osc halted", 1'b0, osc_run)
        @(posedge core_clk);
        wake_req <= 1'b0;
        #1;
        `CHK("osc woken", 1'b1, osc_run)
        `CHK("ready woken", 1'b1, op_ready)
        halted_m = 1'b0;
        do_op(mar_pkg::MAR_OP_ROTATE_RIGHT, 1'b0, 5'h05, 8'h01);
        stop_test();
    end
endmodule
